// file: design/ptp_stamp_pkg.sv
// constants, op codes, register map and stamp arithmetic for the ptp stamp control
// assumes one clock domain carries both the tx and rx system timers
package ptp_stamp_pkg;

  // ----------------------------------------------------------------
  // widths and timer layout
  // ----------------------------------------------------------------
  localparam int TIMER_W = 80;
  localparam int SEC_W = 48;
  localparam int NS_W = 32;
  localparam int TAG_W = 16;
  localparam int OP_W = 2;
  localparam int ADJ_W = 11;
  localparam int ADJ_FRAC_W = 3;
  localparam int ADJ_NS_W = ADJ_W - ADJ_FRAC_W;
  localparam int TC_SIGN_BIT = 63;
  localparam int TC_FRAC_W = 16;
  localparam int TC_ADJ_SHIFT = TC_FRAC_W - ADJ_FRAC_W;
  localparam logic [NS_W-1:0] NS_PER_SEC = 32'h3b9aca00;
  localparam logic [SEC_W-1:0] SEC_ONE = 48'h1;

  // ----------------------------------------------------------------
  // tag fifo
  // ----------------------------------------------------------------
  localparam int FIFO_DEPTH = 4;
  localparam int FIFO_AW = 2;
  localparam int ENTRY_W = TAG_W + TIMER_W;

  // ----------------------------------------------------------------
  // per-frame operation codes
  // ----------------------------------------------------------------
  localparam logic [OP_W-1:0] OP_NONE = 2'h0;
  localparam logic [OP_W-1:0] OP_ONE_STEP = 2'h1;
  localparam logic [OP_W-1:0] OP_TWO_STEP = 2'h2;
  localparam logic [OP_W-1:0] OP_RESERVED = 2'h3;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 8'h08;
  localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 8'h0c;
  localparam int CTRL_ONE_STEP_BIT = 0;
  localparam int CTRL_TRANSP_BIT = 1;
  localparam int CTRL_ADJ_LSB = 2;
  localparam int CTRL_PATH_RST_BIT = 16;
  localparam int ST_WR_ERR_BIT = 0;
  localparam int ST_RD_ERR_BIT = 1;
  localparam int ST_EMPTY_BIT = 2;
  localparam int ST_FULL_BIT = 3;
  localparam int ST_IN_FRAME_BIT = 4;
  localparam int IRQ_W = 3;
  localparam int IRQ_STAMP_BIT = 0;
  localparam int IRQ_WR_ERR_BIT = 1;
  localparam int IRQ_RD_ERR_BIT = 2;
  localparam logic [ADJ_W-1:0] ADJ_RESET = 11'h000;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 3'h0;

  typedef enum logic [0:0] {TX_IDLE, TX_IN_FRAME} txState_t;

  // one-step and two-step frames both take a stamp and a tag slot
  function automatic logic isStamped(input logic [OP_W-1:0] op);
    return (op == OP_ONE_STEP) || (op == OP_TWO_STEP);
  endfunction

  // a correction value is always taken as positive
  function automatic logic [TIMER_W-1:0] captureTime(input logic [TIMER_W-1:0] t,
                                                     input logic tc);
    logic [TIMER_W-1:0] r;
    r = t;
    if (tc) begin
      r[TC_SIGN_BIT] = 1'b0;
    end
    return r;
  endfunction

  // normal format drops the fractional adjust bits: it has no sub-ns field
  function automatic logic [TIMER_W-1:0] applyLatency(input logic [TIMER_W-1:0] t,
                                                      input logic [ADJ_W-1:0] adj,
                                                      input logic tc);
    logic [NS_W:0] ns;
    logic [TIMER_W-1:0] r;
    ns = {1'b0, t[NS_W-1:0]} + {{(NS_W+1-ADJ_NS_W){1'b0}}, adj[ADJ_W-1:ADJ_FRAC_W]};
    r = t;
    if (tc) begin
      r = t + {{(TIMER_W-ADJ_W-TC_ADJ_SHIFT){1'b0}}, adj, {TC_ADJ_SHIFT{1'b0}}};
      r[TC_SIGN_BIT] = 1'b0;
    end else if (ns >= {1'b0, NS_PER_SEC}) begin
      r[NS_W-1:0] = ns[NS_W-1:0] - NS_PER_SEC;
      r[TIMER_W-1:NS_W] = t[TIMER_W-1:NS_W] + SEC_ONE;
    end else begin
      r[NS_W-1:0] = ns[NS_W-1:0];
    end
    return r;
  endfunction

endpackage

// file: design/tag_fifo_if.sv
// bundle between the stamp control and its tag fifo
// assumes both ends run on the same clock
`timescale 1ns/10ps
interface tag_fifo_if
  import ptp_stamp_pkg::*;
();
  logic push;
  logic pop;
  logic flush;
  logic full;
  logic empty;
  logic [ENTRY_W-1:0] pushData;
  logic [ENTRY_W-1:0] popData;

  modport store(input push, input pop, input flush, input pushData,
                output full, output empty, output popData);
  modport user(output push, output pop, output flush, output pushData,
               input full, input empty, input popData);
endinterface

// file: design/tag_fifo.sv
// small show-ahead fifo of tag and stamp pairs
// assumes the user never relies on a push to a full or a pop from an empty fifo
`timescale 1ns/10ps
module tag_fifo
  import ptp_stamp_pkg::*;
(
  input wire logic clk,
  input wire logic rstN,
  tag_fifo_if.store port
);

  logic [ENTRY_W-1:0] mem [FIFO_DEPTH];
  logic [FIFO_AW-1:0] wrPtr_reg, wrPtr_next, rdPtr_reg, rdPtr_next;
  logic [FIFO_AW:0] count_reg, count_next;
  logic doPush, doPop;

  // the count is one bit wider than the pointers so that full and empty differ
  assign port.full = (count_reg == (FIFO_AW+1)'(FIFO_DEPTH));
  assign port.empty = (count_reg == '0);
  assign port.popData = mem[rdPtr_reg];

  // refused requests leave the pointers alone; the user flags them
  always_comb begin
    doPush = port.push && !port.full;
    doPop = port.pop && !port.empty;
    wrPtr_next = wrPtr_reg + FIFO_AW'(doPush);
    rdPtr_next = rdPtr_reg + FIFO_AW'(doPop);
    count_next = count_reg + (FIFO_AW+1)'(doPush) - (FIFO_AW+1)'(doPop);
    if (port.flush) begin
      wrPtr_next = '0;
      rdPtr_next = '0;
      count_next = '0;
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end else begin
      wrPtr_reg <= wrPtr_next;
      rdPtr_reg <= rdPtr_next;
      count_reg <= count_next;
    end
  end

  always_ff @(posedge clk) begin
    if (doPush) begin
      mem[wrPtr_reg] <= port.pushData;
    end
  end

endmodule

// file: design/ptp_stamp_ctrl.sv
// ptp timestamp control for the transmit and receive paths of the mac
// assumes tx and rx timers and frame strobes are synchronous to clk
`timescale 1ns/10ps
// Operation
// - one-step insertion happens only while the one-step enable is 1.
// - one-step stamp offset by 11-bit adjust, ns on 10:3, fraction 2:0.
// - transparent mode treats timer as a correction, carried as the tx stamp.
// - the correction sign bit is forced to zero, always positive.
// - failed tag fifo write sets a flag held until tx path reset.
// - failed tag fifo read sets a separate flag cleared by tx path reset.
// - op code 00 takes no stamp and leaves the frame untouched.
// - op code 01 takes a stamp and inserts it into the frame.
// - op code 10 returns the stamp on the two-step ports, frame untouched.
// - op code 11 behaves exactly as code 00.
// - one-step and two-step stamps come back with the frame's 16-bit tag.
// - a valid bit marks each 80-bit stamp shown on the two-step output.
module ptp_stamp_ctrl
  import ptp_stamp_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [DATA_W-1:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [DATA_W-1:0] regRdData,
  output logic irq,
  input wire logic [TIMER_W-1:0] txTimer,
  input wire logic [TIMER_W-1:0] rxTimer,
  input wire logic txSop,
  input wire logic txEop,
  input wire logic [OP_W-1:0] frameStampOperation,
  input wire logic [TAG_W-1:0] txTagIn,
  input wire logic rxSop,
  output logic oneStepInsertValid,
  output logic [TIMER_W-1:0] oneStepStamp,
  output logic twoStepValid,
  output logic [TAG_W-1:0] twoStepTag,
  output logic [TIMER_W-1:0] twoStepStamp,
  output logic rxStampValid,
  output logic [TIMER_W-1:0] rxStamp,
  output logic fifoWriteError,
  output logic fifoReadError
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rstMeta_reg, rstN;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rstMeta_reg <= 1'b0;
      rstN <= 1'b0;
    end else begin
      rstMeta_reg <= 1'b1;
      rstN <= rstMeta_reg;
    end
  end

  // ----------------------------------------------------------------
  // tag fifo
  // ----------------------------------------------------------------
  tag_fifo_if fifoBus();

  tag_fifo u_tag_fifo (
    .clk(clk),
    .rstN(rstN),
    .port(fifoBus.store)
  );

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  logic oneStepInsertEnable_reg, oneStepInsertEnable_next;
  logic transp_reg, transp_next;
  logic [ADJ_W-1:0] latAdj_reg, latAdj_next;
  logic [IRQ_W-1:0] irqStat_reg, irqStat_next, irqMask_reg, irqMask_next, events;
  logic [DATA_W-1:0] regRdData_next;
  logic irq_next, pathRst;
  txState_t txState_reg, txState_next;
  logic [FIFO_AW:0] pendCnt_reg, pendCnt_next;
  logic wrErr_reg, wrErr_next, rdErr_reg, rdErr_next;

  always_comb begin
    oneStepInsertEnable_next = oneStepInsertEnable_reg;
    transp_next = transp_reg;
    latAdj_next = latAdj_reg;
    irqMask_next = irqMask_reg;
    pathRst = 1'b0;
    // set wins over a write-one clear landing in the same cycle
    irqStat_next = irqStat_reg | events;
    if (regWr) begin
      case (regAddr)
        REG_CTRL: begin
          oneStepInsertEnable_next = regWrData[CTRL_ONE_STEP_BIT];
          transp_next = regWrData[CTRL_TRANSP_BIT];
          latAdj_next = regWrData[CTRL_ADJ_LSB +: ADJ_W];
          pathRst = regWrData[CTRL_PATH_RST_BIT];
        end
        REG_IRQ_STAT: irqStat_next = (irqStat_reg & ~regWrData[IRQ_W-1:0]) | events;
        REG_IRQ_MASK: irqMask_next = regWrData[IRQ_W-1:0];
        default: ;
      endcase
    end
    irq_next = |(irqStat_next & irqMask_next);
    regRdData_next = '0;
    if (regRd) begin
      case (regAddr)
        REG_CTRL: begin
          regRdData_next[CTRL_ONE_STEP_BIT] = oneStepInsertEnable_reg;
          regRdData_next[CTRL_TRANSP_BIT] = transp_reg;
          regRdData_next[CTRL_ADJ_LSB +: ADJ_W] = latAdj_reg;
        end
        REG_STATUS: begin
          regRdData_next[ST_WR_ERR_BIT] = wrErr_reg;
          regRdData_next[ST_RD_ERR_BIT] = rdErr_reg;
          regRdData_next[ST_EMPTY_BIT] = fifoBus.empty;
          regRdData_next[ST_FULL_BIT] = fifoBus.full;
          regRdData_next[ST_IN_FRAME_BIT] = (txState_reg == TX_IN_FRAME);
        end
        REG_IRQ_STAT: regRdData_next[IRQ_W-1:0] = irqStat_reg;
        REG_IRQ_MASK: regRdData_next[IRQ_W-1:0] = irqMask_reg;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      oneStepInsertEnable_reg <= 1'b0;
      transp_reg <= 1'b0;
      latAdj_reg <= ADJ_RESET;
      irqStat_reg <= '0;
      irqMask_reg <= IRQ_MASK_RESET;
      irq <= 1'b0;
      regRdData <= '0;
    end else begin
      oneStepInsertEnable_reg <= oneStepInsertEnable_next;
      transp_reg <= transp_next;
      latAdj_reg <= latAdj_next;
      irqStat_reg <= irqStat_next;
      irqMask_reg <= irqMask_next;
      irq <= irq_next;
      regRdData <= regRdData_next;
    end
  end

  // ----------------------------------------------------------------
  // transmit stamping
  // ----------------------------------------------------------------
  logic [TIMER_W-1:0] txCapture;
  logic sopStamped, sopOneStep, popTake, popOk;
  logic oneValid_next, twoValid_next;
  logic [TIMER_W-1:0] oneStamp_next, twoStamp_next;
  logic [TAG_W-1:0] twoTag_next, popTag;

  // in transparent mode the timer is a correction, carried as the stamp
  assign txCapture = captureTime(txTimer, transp_reg);
  assign sopStamped = txSop && isStamped(frameStampOperation);
  assign sopOneStep = txSop && (frameStampOperation == OP_ONE_STEP)
                      && oneStepInsertEnable_reg;
  // sop and eop of one frame are expected in different cycles; every stamped start,
  // kept or refused, up to seven outstanding, owes one pop at its end, so a lost entry shows up as a read error
  assign popTake = txEop && (pendCnt_reg != '0);
  assign popOk = popTake && !fifoBus.empty;
  assign popTag = fifoBus.popData[ENTRY_W-1 -: TAG_W];
  assign fifoBus.push = sopStamped;
  assign fifoBus.pushData = {txTagIn, txCapture};
  assign fifoBus.pop = popTake;
  assign fifoBus.flush = pathRst;
  assign events[IRQ_STAMP_BIT] = popOk;
  assign events[IRQ_WR_ERR_BIT] = sopStamped && fifoBus.full;
  assign events[IRQ_RD_ERR_BIT] = popTake && fifoBus.empty;

  always_comb begin
    txState_next = txState_reg;
    wrErr_next = wrErr_reg || events[IRQ_WR_ERR_BIT];
    rdErr_next = rdErr_reg || events[IRQ_RD_ERR_BIT];
    pendCnt_next = pendCnt_reg - (FIFO_AW+1)'(popTake);
    if (sopStamped && (pendCnt_reg != '1)) begin
      pendCnt_next = pendCnt_next + (FIFO_AW+1)'(1);
    end
    oneValid_next = sopOneStep;
    oneStamp_next = oneStepStamp;
    twoValid_next = popOk;
    twoTag_next = twoStepTag;
    twoStamp_next = twoStepStamp;
    if (sopOneStep) begin
      oneStamp_next = applyLatency(txCapture, latAdj_reg, transp_reg);
    end
    if (popOk) begin
      twoTag_next = popTag;
      twoStamp_next = fifoBus.popData[TIMER_W-1:0];
    end
    case (txState_reg)
      TX_IDLE: begin
        if (sopStamped) begin
          txState_next = TX_IN_FRAME;
        end
      end
      TX_IN_FRAME: begin
        if (pendCnt_next == '0) begin
          txState_next = TX_IDLE;
        end
      end
      default: txState_next = TX_IDLE;
    endcase
    // only the path reset clears the error flags
    // an error event in the reset cycle itself still sets its flag
    if (pathRst) begin
      txState_next = TX_IDLE;
      wrErr_next = events[IRQ_WR_ERR_BIT];
      rdErr_next = events[IRQ_RD_ERR_BIT];
      pendCnt_next = '0;
      oneValid_next = 1'b0;
      twoValid_next = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      txState_reg <= TX_IDLE;
      pendCnt_reg <= '0;
      wrErr_reg <= 1'b0;
      rdErr_reg <= 1'b0;
      oneStepInsertValid <= 1'b0;
      oneStepStamp <= '0;
      twoStepValid <= 1'b0;
      twoStepTag <= '0;
      twoStepStamp <= '0;
      fifoWriteError <= 1'b0;
      fifoReadError <= 1'b0;
    end else begin
      txState_reg <= txState_next;
      pendCnt_reg <= pendCnt_next;
      wrErr_reg <= wrErr_next;
      rdErr_reg <= rdErr_next;
      oneStepInsertValid <= oneValid_next;
      oneStepStamp <= oneStamp_next;
      twoStepValid <= twoValid_next;
      twoStepTag <= twoTag_next;
      twoStepStamp <= twoStamp_next;
      fifoWriteError <= wrErr_next;
      fifoReadError <= rdErr_next;
    end
  end

  // ----------------------------------------------------------------
  // receive stamping
  // ----------------------------------------------------------------
  logic [TIMER_W-1:0] rxStamp_next;

  always_comb begin
    rxStamp_next = rxStamp;
    if (rxSop) begin
      rxStamp_next = captureTime(rxTimer, transp_reg);
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      rxStampValid <= 1'b0;
      rxStamp <= '0;
    end else begin
      rxStampValid <= rxSop;
      rxStamp <= rxStamp_next;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstN);

  one_step_gate_a: assert property (oneStepInsertValid |-> $past(oneStepInsertEnable_reg))
    else $error("one-step stamp issued while disabled");
  zero_adjust_a: assert property (sopOneStep && latAdj_reg == '0 |=>
    oneStepStamp == $past(txCapture))
    else $error("one-step stamp moved with zero adjust");
  tc_sign_zero_a: assert property (rxSop && transp_reg |=> !rxStamp[TC_SIGN_BIT])
    else $error("correction sign bit not forced to zero");
  wr_err_hold_a: assert property (fifoWriteError && !pathRst |=> fifoWriteError)
    else $error("write error flag dropped without path reset");
  wr_err_set_a: assert property (sopStamped && fifoBus.full && !pathRst |=>
    fifoWriteError)
    else $error("refused tag write not flagged");
  rd_err_hold_a: assert property (fifoReadError && !pathRst |=> fifoReadError)
    else $error("read error flag dropped without path reset");
  rd_err_set_a: assert property (popTake && fifoBus.empty && !pathRst |=>
    fifoReadError)
    else $error("refused tag read not flagged");
  no_stamp_a: assert property (txSop && !isStamped(frameStampOperation) &&
    fifoBus.empty && !pathRst |=> fifoBus.empty)
    else $error("unstamped frame took a tag slot");
  two_step_tag_a: assert property (popOk && !pathRst |=> twoStepValid &&
    twoStepTag == $past(popTag))
    else $error("two-step tag does not match the frame");
  rx_sample_a: assert property (rxSop && !transp_reg |=> rxStampValid &&
    rxStamp == $past(rxTimer))
    else $error("rx stamp is not the start-of-frame timer");

  one_step_c: cover property (sopOneStep ##1 oneStepInsertValid);
  two_step_c: cover property (sopStamped ##[1:8] twoStepValid);
  wr_err_c: cover property ($rose(fifoWriteError));
  rd_err_c: cover property ($rose(fifoReadError));

endmodule

// file: bench/ptp_time_source.sv
// model of the external system time source feeding both timer inputs
// assumes one clock for tx and rx; format follows the tb's transparent mode choice
`timescale 1ns/10ps
module ptp_time_source
  import ptp_stamp_pkg::*;
(
  input wire logic clk,
  input wire logic rstN,
  input wire logic tcMode,
  input wire logic forceSign,
  output logic [TIMER_W-1:0] txTimer,
  output logic [TIMER_W-1:0] rxTimer
);
  // ----------------------------------------------------------------
  // timers
  // ----------------------------------------------------------------
  // start 400 ns below a second boundary so that adjusted stamps carry
  localparam logic [NS_W-1:0] NS_START = 32'h3b9ac870;
  logic [SEC_W-1:0] secReg;
  logic [NS_W-1:0] nsReg;
  logic [TIMER_W-1:0] corrReg;

  // advances 4 ns a cycle, the clock period, with a seconds carry
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      secReg <= 48'h1;
      nsReg <= NS_START;
      corrReg <= 80'h00ab_0000_0012_3456_0000;
    end else begin
      // correction stands for a field already adjusted by the rx stamp
      corrReg <= corrReg + 80'h4_0000;
      if (nsReg + 32'h4 >= NS_PER_SEC) begin
        nsReg <= nsReg + 32'h4 - NS_PER_SEC;
        secReg <= secReg + 48'h1;
      end else begin
        nsReg <= nsReg + 32'h4;
      end
    end
  end

  // forceSign breaks the zero sign bit on purpose
  assign txTimer = tcMode ? {corrReg[79:64], forceSign, corrReg[62:0]} : {secReg, nsReg};
  assign rxTimer = tcMode ? {corrReg[79:64], forceSign, corrReg[62:16], 16'h0123} :
                   {secReg + 48'h100, nsReg};
endmodule

// file: bench/tb.sv
// self-checking bench: register bus, tx one-step and two-step stamps, rx stamps, fifo errors
// assumes the time source model drives both timers; all inputs change by nba after posedge
`timescale 1ns/10ps
module tb;
  import ptp_stamp_pkg::*;
  logic clk, reset_n, regWr, regRd, txSop, txEop, rxSop, tcMode, forceSign, enable, rdPend;
  logic irq, oneStepInsertValid, twoStepValid, rxStampValid, fifoWriteError, fifoReadError;
  logic [ADDR_W-1:0] regAddr;
  logic [DATA_W-1:0] regWrData, regRdData;
  logic [OP_W-1:0] frameStampOperation;
  logic [TAG_W-1:0] txTagIn, twoStepTag;
  logic [TIMER_W-1:0] txTimer, rxTimer, oneStepStamp, twoStepStamp, rxStamp;
  logic [ADJ_W-1:0] adj;
  logic [31:0] rng;
  logic [TIMER_W-1:0] oneQ[$], twoQ[$], rxQ[$];
  logic [TAG_W-1:0] tagQ[$];
  logic [DATA_W-1:0] rdQ[$];
  int miscompares, n_tests, fifoCnt;

  ptp_time_source u_src (.clk(clk), .rstN(reset_n), .tcMode(tcMode), .forceSign(forceSign),
    .txTimer(txTimer), .rxTimer(rxTimer));
  ptp_stamp_ctrl u_dut (.clk(clk), .reset_n(reset_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .irq(irq), .txTimer(txTimer),
    .rxTimer(rxTimer), .txSop(txSop), .txEop(txEop), .frameStampOperation(frameStampOperation),
    .txTagIn(txTagIn), .rxSop(rxSop), .oneStepInsertValid(oneStepInsertValid),
    .oneStepStamp(oneStepStamp), .twoStepValid(twoStepValid), .twoStepTag(twoStepTag),
    .twoStepStamp(twoStepStamp), .rxStampValid(rxStampValid), .rxStamp(rxStamp),
    .fifoWriteError(fifoWriteError), .fifoReadError(fifoReadError));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // one-step stamp: normal format adds whole ns only, tc format adds the aligned adjust
  function automatic logic [TIMER_W-1:0] expOne(input logic [TIMER_W-1:0] t);
    logic [TIMER_W-1:0] r;
    logic [32:0] ns;
    r = t;
    ns = {1'b0, t[31:0]} + {25'h0, adj[10:3]};
    if (tcMode) begin
      r = t + {56'h0, adj, 13'h0};
      r[63] = 1'b0;
    end else if (ns >= 33'h03b9aca00) begin
      r[31:0] = ns[31:0] - 32'h3b9aca00;
      r[79:32] = t[79:32] + 48'h1;
    end else begin
      r[31:0] = ns[31:0];
    end
    return r;
  endfunction

  task automatic cmpStamp(input string nm, input logic [TIMER_W-1:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cmpTag(input string nm, input logic [TAG_W-1:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cmpWord(input string nm, input logic [DATA_W-1:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cmpFlag(input string nm, input logic seen, exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %b seen %b", nm, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic regWrite(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic regRead(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    rdQ.push_back(exp);
    @(posedge clk);
    regRd <= 1'b0;
  endtask
  task automatic setCtrl(input logic en, tc, input logic [ADJ_W-1:0] a, input logic rst);
    enable = en;
    adj = a;
    tcMode <= tc;
    regWrite(REG_CTRL, {15'h0, rst, 3'h0, a, tc, en});
    if (rst) begin
      fifoCnt = 0;
    end
  endtask

  // the expectation is noted at the edge that takes the frame start
  task automatic sendSop(input logic [OP_W-1:0] op);
    logic [TIMER_W-1:0] t;
    rng = xs(rng);
    @(posedge clk);
    txSop <= 1'b1;
    frameStampOperation <= op;
    txTagIn <= rng[TAG_W-1:0];
    @(posedge clk);
    t = txTimer;
    if (op == OP_ONE_STEP && enable) begin
      oneQ.push_back(expOne(t));
    end
    if ((op == OP_ONE_STEP || op == OP_TWO_STEP) && fifoCnt < FIFO_DEPTH) begin
      fifoCnt++;
      t[TC_SIGN_BIT] = t[TC_SIGN_BIT] & !tcMode;
      twoQ.push_back(t);
      tagQ.push_back(rng[TAG_W-1:0]);
    end
    txSop <= 1'b0;
  endtask
  task automatic sendEop();
    @(posedge clk);
    txEop <= 1'b1;
    @(posedge clk);
    fifoCnt = (fifoCnt > 0) ? fifoCnt - 1 : 0;
    txEop <= 1'b0;
  endtask
  task automatic rxBurst(input int n);
    logic [TIMER_W-1:0] t;
    @(posedge clk);
    rxSop <= 1'b1;
    repeat (n) begin
      @(posedge clk);
      t = rxTimer;
      t[TC_SIGN_BIT] = t[TC_SIGN_BIT] & !tcMode;
      rxQ.push_back(t);
    end
    rxSop <= 1'b0;
  endtask

  // ----------------------------------------------------------------
  // monitor: an empty queue yields an all-x note, which never matches
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (rdPend) begin
      cmpWord("regRdData", regRdData, rdQ.size() > 0 ? rdQ.pop_front() : 'x);
    end
    rdPend = (regRd === 1'b1);
    if (oneStepInsertValid === 1'b1) begin
      cmpStamp("oneStepStamp", oneStepStamp, oneQ.size() > 0 ? oneQ.pop_front() : 'x);
    end
    if (twoStepValid === 1'b1) begin
      cmpTag("twoStepTag", twoStepTag, tagQ.size() > 0 ? tagQ.pop_front() : 'x);
      cmpStamp("twoStepStamp", twoStepStamp, twoQ.size() > 0 ? twoQ.pop_front() : 'x);
    end
    if (rxStampValid === 1'b1) begin
      cmpStamp("rxStamp", rxStamp, rxQ.size() > 0 ? rxQ.pop_front() : 'x);
    end
  end

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    tick(20000);
    miscompares++;
    $display("MISMATCH run expected end seen hang");
    conclude();
  end

  initial begin
    {reset_n, regWr, regRd, txSop, txEop, rxSop, tcMode, forceSign, enable, rdPend} = 10'h0;
    regAddr = 8'h00;
    regWrData = 32'h0;
    frameStampOperation = OP_NONE;
    txTagIn = 16'h0;
    adj = ADJ_RESET;
    rng = 32'h00000061;
    fifoCnt = 0;
    tick(5);
    reset_n <= 1'b1;
    tick(3);
    cmpFlag("irq", irq, 1'b0);
    cmpStamp("twoStepStamp", twoStepStamp, 80'h0);
    regRead(REG_CTRL, 32'h0);
    regRead(REG_STATUS, 32'h4);
    regRead(REG_IRQ_STAT, 32'h0);
    regWrite(8'h10, 32'hffffffff);
    regRead(REG_IRQ_MASK, 32'h0);
    regRead(8'h10, 32'h0);
    rng = xs(rng);
    setCtrl(1'b1, 1'b0, {1'b1, rng[9:0]}, 1'b0);
    regRead(REG_CTRL, {19'h0, adj, 2'h1});
    for (int i = 0; i < 8; i++) begin
      sendSop(OP_W'(i));
      sendEop();
      rxBurst(i % 3 + 1);
    end
    setCtrl(1'b0, 1'b0, adj, 1'b0);
    sendSop(OP_ONE_STEP);
    sendEop();
    setCtrl(1'b1, 1'b1, adj, 1'b0);
    forceSign <= 1'b1;
    sendSop(OP_ONE_STEP);
    sendEop();
    sendSop(OP_TWO_STEP);
    sendEop();
    rxBurst(3);
    forceSign <= 1'b0;
    setCtrl(1'b1, 1'b0, adj, 1'b0);
    regRead(REG_IRQ_STAT, 32'h1);
    regWrite(REG_IRQ_MASK, 32'h1);
    tick(3);
    cmpFlag("irq", irq, 1'b1);
    regWrite(REG_IRQ_STAT, 32'h1);
    tick(3);
    cmpFlag("irq", irq, 1'b0);
    for (int i = 0; i < 5; i++) begin
      sendSop(OP_TWO_STEP);
    end
    tick(2);
    cmpFlag("fifoWriteError", fifoWriteError, 1'b1);
    regRead(REG_STATUS, 32'h19);
    for (int i = 0; i < 5; i++) begin
      sendEop();
    end
    tick(2);
    cmpFlag("fifoReadError", fifoReadError, 1'b1);
    cmpFlag("fifoWriteError", fifoWriteError, 1'b1);
    regRead(REG_STATUS, 32'h7);
    regRead(REG_IRQ_STAT, 32'h7);
    regWrite(REG_IRQ_STAT, 32'h7);
    regRead(REG_IRQ_STAT, 32'h0);
    setCtrl(1'b1, 1'b0, adj, 1'b1);
    tick(2);
    cmpFlag("fifoWriteError", fifoWriteError, 1'b0);
    cmpFlag("fifoReadError", fifoReadError, 1'b0);
    regRead(REG_STATUS, 32'h4);
    setCtrl(1'b1, 1'b0, ADJ_RESET, 1'b0);
    sendSop(OP_ONE_STEP);
    sendEop();
    regRead(REG_CTRL, {19'h0, adj, 2'h1});
    for (int i = 0; i < 50 && oneQ.size() + twoQ.size() + rxQ.size() + rdQ.size() > 0; i++) begin
      @(posedge clk);
    end
    cmpWord("pending", 32'(oneQ.size() + twoQ.size() + rxQ.size() + rdQ.size()), 32'h0);
    conclude();
  end
endmodule
